// [ulsr_pkg.sv]
// constants and types for the receive line status block
package ulsr_pkg;

  // =======================================
  // sizes
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;

  // =======================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_RX_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_LINE_STATUS = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_DIVISOR = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_INT_CLEAR = 3'h6;

  // =======================================
  // line status bit positions
  localparam int LS_DR = 0;
  localparam int LS_OE = 1;
  localparam int LS_PE = 2;
  localparam int LS_FE = 3;
  localparam int LS_BI = 4;
  localparam int LS_FERR = 7;

  // interrupt bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_LINE = 1;

  // =======================================
  // reset values
  localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h18;
  localparam logic [DATA_W-1:0] DIVISOR_RESET = 8'h01;
  localparam logic [1:0] INT_RESET = 2'h0;

  // oversampling
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;

  // =======================================
  // types
  typedef struct packed {
    logic [2:0] rsvd;
    logic [1:0] wlen;
    logic even;
    logic par_en;
    logic fifo_en;
  } ulsr_cfg_t;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [DATA_W-1:0] data;
  } ulsr_char_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP = 3'b100,
    ST_BRK_WAIT = 3'b101
  } ulsr_state_t;

endpackage

// [ulsr_top.sv]
// receiver, fifo and line status register of the uart receive side
//
// Overview of operation
// - a frame in which the line stays low from start to stop bit is a break.
// - in fifo mode one break gives one break character, however long the line stays low.
// - status bit 3 flags a character, other than a break, whose stop bit was low.
// - in fifo mode the framing flag follows the character at the top of the fifo.
// - status bit 2 flags a character, other than a break, whose parity is wrong for the configured parity.
// - in fifo mode the parity flag follows the character at the top of the fifo.
// - status bit 1 flags a character completed while the fifo is full.
// - an overrun character is dropped and the fifo contents stay intact.
// - status bit 0 is high while any received character is held.
// - all these flags read 0 when nothing is pending, as after reset.
// - in fifo mode status bit 7 is set when error data enters the fifo and clears on a status read.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns

module ulsr_top
  import ulsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic rx_i,
  output logic irq_o
);

  // =======================================
  // register decode
  logic wr_cfg;
  logic wr_div;
  logic wr_ien;
  logic wr_iclr;
  logic rd_ls;
  logic rd_rx;

  assign wr_cfg = wr_i && (addr_i == OFS_CONFIG);
  assign wr_div = wr_i && (addr_i == OFS_DIVISOR);
  assign wr_ien = wr_i && (addr_i == OFS_INT_ENABLE);
  assign wr_iclr = wr_i && (addr_i == OFS_INT_CLEAR);
  assign rd_ls = rd_i && (addr_i == OFS_LINE_STATUS);
  assign rd_rx = rd_i && (addr_i == OFS_RX_DATA);

  ulsr_cfg_t cfg_reg;
  logic [DATA_W-1:0] div_reg;
  logic [1:0] int_en_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_reg <= ulsr_cfg_t'(CONFIG_RESET);
    end else if (wr_cfg) begin
      cfg_reg <= ulsr_cfg_t'(wdata_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_reg <= DIVISOR_RESET;
    end else if (wr_div) begin
      div_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      int_en_reg <= INT_RESET;
    end else if (wr_ien) begin
      int_en_reg <= wdata_i[1:0];
    end
  end

  // =======================================
  // 16x baud enable; a divisor of zero acts as 256
  logic [DATA_W-1:0] baud_cnt_reg;
  logic tick;

  assign tick = (baud_cnt_reg == 8'h00);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      baud_cnt_reg <= 8'h00;
    end else if (tick) begin
      baud_cnt_reg <= div_reg - 8'h01;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 8'h01;
    end
  end

  // =======================================
  // receive shift register
  ulsr_state_t state_reg;
  logic [3:0] os_reg;
  logic [2:0] bit_reg;
  logic [DATA_W-1:0] shift_reg;
  logic par_reg;
  logic zero_reg;
  logic [2:0] last_bit;
  logic os_end;
  logic char_done;

  assign last_bit = {1'b1, cfg_reg.wlen};
  assign os_end = tick && (os_reg == OS_LAST);
  assign char_done = os_end && (state_reg == ST_STOP);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      os_reg <= 4'h0;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      par_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else if (tick) begin
      os_reg <= os_reg + 4'h1;
      unique case (state_reg)
        ST_IDLE: begin
          os_reg <= 4'h0;
          if (!rx_i) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          // a glitch shorter than half a bit is a false start
          if (os_reg == OS_MID) begin
            os_reg <= 4'h0;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            par_reg <= 1'b0;
            zero_reg <= 1'b1;
            state_reg <= rx_i ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (os_reg == OS_LAST) begin
            shift_reg[bit_reg] <= rx_i;
            par_reg <= par_reg ^ rx_i;
            zero_reg <= zero_reg & ~rx_i;
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == last_bit) begin
              state_reg <= cfg_reg.par_en ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (os_reg == OS_LAST) begin
            par_reg <= par_reg ^ rx_i;
            zero_reg <= zero_reg & ~rx_i;
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          // only the first stop bit is checked
          if (os_reg == OS_LAST) begin
            state_reg <= (zero_reg && !rx_i) ? ST_BRK_WAIT : ST_IDLE;
          end
        end
        ST_BRK_WAIT: begin
          // hold here until the line idles so a long break loads once
          if (rx_i) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ulsr_char_t new_char;
  logic is_brk;

  assign is_brk = zero_reg && !rx_i;
  assign new_char.brk = is_brk;
  assign new_char.fe = !rx_i && !is_brk;
  assign new_char.pe = cfg_reg.par_en && (par_reg ^ ~cfg_reg.even) && !is_brk;
  assign new_char.data = shift_reg;

  // =======================================
  // receive fifo; depth one acts as the holding register
  ulsr_char_t mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_reg;
  logic [PTR_W-1:0] rp_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic full;
  logic push;
  logic pop;
  logic ovr_evt;
  logic flush;
  ulsr_char_t top;

  assign full = cfg_reg.fifo_en ? (cnt_reg == FIFO_FULL) : (cnt_reg != CNT_ZERO);
  assign push = char_done && !full;
  assign ovr_evt = char_done && full;
  assign pop = rd_rx && (cnt_reg != CNT_ZERO);
  assign flush = wr_cfg && (wdata_i[0] != cfg_reg.fifo_en);
  assign top = mem[rp_reg];

  always_ff @(posedge clk_i) begin
    if (push) begin
      // holding register mode always writes the slot that the reader sees
      mem[cfg_reg.fifo_en ? wp_reg : rp_reg] <= new_char;
    end
  end

  // overrun never pushes, so the held data stays as it was
  always_ff @(posedge clk_i) begin
    if (reset_i || flush) begin
      wp_reg <= 4'h0;
      rp_reg <= 4'h0;
      cnt_reg <= CNT_ZERO;
    end else begin
      if (push) begin
        wp_reg <= (cfg_reg.fifo_en ? wp_reg : rp_reg) + PTR_ONE;
      end
      if (pop) begin
        rp_reg <= rp_reg + PTR_ONE;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + CNT_ONE;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - CNT_ONE;
      end
    end
  end

  // =======================================
  // line status flags; an event in the read cycle survives the clear
  logic top_seen_reg;
  logic top_evt;
  logic [2:0] err_reg;
  logic ovr_reg;
  logic ferr_reg;
  logic [DATA_W-1:0] ls_word;

  assign top_evt = (cnt_reg != CNT_ZERO) && !top_seen_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i || flush || pop) begin
      top_seen_reg <= 1'b0;
    end else if (cnt_reg != CNT_ZERO) begin
      top_seen_reg <= 1'b1;
    end
  end

  // {break, framing, parity} of the character reaching the top
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      err_reg <= 3'h0;
    end else begin
      err_reg <= (err_reg & ~{3{rd_ls}}) | ({3{top_evt}} & {top.brk, top.fe, top.pe});
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ovr_reg <= 1'b0;
    end else begin
      ovr_reg <= (ovr_reg && !rd_ls) || ovr_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || flush) begin
      ferr_reg <= 1'b0;
    end else begin
      ferr_reg <= (ferr_reg && !rd_ls) ||
                  (push && cfg_reg.fifo_en && (new_char.brk || new_char.fe || new_char.pe));
    end
  end

  assign ls_word = {ferr_reg, 2'b00, err_reg, ovr_reg, cnt_reg != CNT_ZERO};

  // =======================================
  // interrupts
  logic [1:0] int_st_reg;
  logic [1:0] int_set;

  assign int_set[IRQ_RX] = push;
  assign int_set[IRQ_LINE] = ovr_evt || (top_evt && (top.brk || top.fe || top.pe));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      int_st_reg <= INT_RESET;
    end else begin
      int_st_reg <= (int_st_reg & ~(wdata_i[1:0] & {2{wr_iclr}})) | int_set;
    end
  end

  assign irq_o = |(int_st_reg & int_en_reg);

  // =======================================
  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i || !rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      unique case (addr_i)
        OFS_RX_DATA: rdata_o <= (cnt_reg != CNT_ZERO) ? top.data : 8'h00;
        OFS_LINE_STATUS: rdata_o <= ls_word;
        OFS_CONFIG: rdata_o <= cfg_reg;
        OFS_DIVISOR: rdata_o <= div_reg;
        OFS_INT_STATUS: rdata_o <= {6'h00, int_st_reg};
        OFS_INT_ENABLE: rdata_o <= {6'h00, int_en_reg};
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // =======================================
  // assertions
  sequence s_break_frame;
    char_done && zero_reg && !rx_i;
  endsequence

  property p_break_hold;
    @(posedge clk_i) disable iff (reset_i)
    s_break_frame |=> (state_reg == ST_BRK_WAIT);
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("break not held");

  property p_one_break;
    @(posedge clk_i) disable iff (reset_i)
    (state_reg == ST_BRK_WAIT) && !rx_i |=> (state_reg == ST_BRK_WAIT) && !char_done;
  endproperty
  a_one_break: assert property (p_one_break) else $error("second break char");

  property p_fe_set;
    @(posedge clk_i) disable iff (reset_i)
    top_evt && top.fe |=> ls_word[LS_FE];
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("framing flag missing");

  property p_fe_top;
    @(posedge clk_i) disable iff (reset_i)
    push && new_char.fe && !top_evt && !err_reg[1] && (cnt_reg != CNT_ZERO)
      |=> !ls_word[LS_FE];
  endproperty
  a_fe_top: assert property (p_fe_top) else $error("framing flag not from top");

  property p_pe_set;
    @(posedge clk_i) disable iff (reset_i)
    top_evt && top.pe |=> ls_word[LS_PE];
  endproperty
  a_pe_set: assert property (p_pe_set) else $error("parity flag missing");

  property p_ovr;
    @(posedge clk_i) disable iff (reset_i)
    ovr_evt |=> ls_word[LS_OE];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun flag missing");

  property p_ovr_keep;
    @(posedge clk_i) disable iff (reset_i)
    ovr_evt && !pop && !flush |=> $stable(cnt_reg) && $stable(wp_reg);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun wrote fifo");

  property p_ready;
    @(posedge clk_i) disable iff (reset_i)
    push && !flush |=> ls_word[LS_DR] ##1 (ls_word[LS_DR] || $past(pop));
  endproperty
  a_ready: assert property (p_ready) else $error("data ready wrong");

  property p_default;
    @(posedge clk_i) disable iff (reset_i)
    $fell(reset_i) |-> (ls_word == 8'h00) && !irq_o;
  endproperty
  a_default: assert property (p_default) else $error("status not clear");

  property p_ferr_clr;
    @(posedge clk_i) disable iff (reset_i)
    rd_ls && !push |=> !ls_word[LS_FERR];
  endproperty
  a_ferr_clr: assert property (p_ferr_clr) else $error("summary not cleared");

  property p_read_clr;
    @(posedge clk_i) disable iff (reset_i)
    rd_ls && !top_evt && !ovr_evt |=> (ls_word[LS_BI:LS_OE] == 4'h0);
  endproperty
  a_read_clr: assert property (p_read_clr) else $error("flags not cleared");

endmodule

// [ulsr_tx_model.sv]
// serial transmitter model driving the receive line of the block
`timescale 1ns/1ns

module ulsr_tx_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_i,
  output logic rx_o
);
  // idle line is high, so a released line never reads as a start bit
  initial rx_o = 1'b1;

  // =======================================
  // one frame: start, eight data bits lsb first, optional parity, one stop
  task automatic send(input logic [7:0] d, input logic par_on, input logic par_bit,
      input logic stop_bit);
    logic [10:0] f;
    int n;
    f = {stop_bit, par_bit, d, 1'b0};
    n = par_on ? 11 : 10;
    if (!par_on) begin
      f[9] = stop_bit;
    end
    for (int i = 0; i < n; i++) begin
      rx_o <= f[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rx_o <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask

  // =======================================
  // line held low well beyond one frame
  task automatic hold_low(input int clks);
    rx_o <= 1'b0;
    repeat (clks) @(posedge clk_i);
    rx_o <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk_i);
  endtask
endmodule

// [ulsr_top_tb_top.sv]
// self-checking testbench of the receive line status block
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end

module ulsr_top_tb_top
  import ulsr_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic rx_i;
  logic irq_o;
  logic [DATA_W-1:0] d;
  int errors = 0;
  int tests_run = 0;

  always #50 clk_i = ~clk_i;

  ulsr_top DUT (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .rx_i(rx_i),
    .irq_o(irq_o)
  );

  ulsr_tx_model tx (
    .clk_i(clk_i),
    .rx_o(rx_i)
  );

  // =======================================
  // register bus
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    `CHK(d, e)
  endtask

  // =======================================
  // scenarios
  task automatic t_idle();
    chk_rd(OFS_LINE_STATUS, 8'h00);
    chk_rd(3'h7, 8'h00);
    chk_rd(OFS_CONFIG, CONFIG_RESET);
    `CHK(irq_o, 1'b0)
    $display("test idle done");
  endtask

  task automatic t_plain();
    tx.send(8'ha5, 1'b0, 1'b0, 1'b1);
    chk_rd(OFS_LINE_STATUS, 8'h01);
    chk_rd(OFS_INT_STATUS, 8'h01);
    // enable still zero, so the pending event is masked
    `CHK(irq_o, 1'b0)
    chk_rd(OFS_RX_DATA, 8'ha5);
    chk_rd(OFS_LINE_STATUS, 8'h00);
    wr(OFS_INT_CLEAR, 8'h03);
    $display("test plain done");
  endtask

  task automatic t_errors();
    wr(OFS_CONFIG, 8'h1e);
    wr(OFS_INT_ENABLE, 8'h02);
    tx.send(8'ha5, 1'b1, 1'b1, 1'b1);
    `CHK(irq_o, 1'b1)
    chk_rd(OFS_LINE_STATUS, 8'h05);
    chk_rd(OFS_LINE_STATUS, 8'h01);
    chk_rd(OFS_INT_STATUS, 8'h03);
    wr(OFS_INT_CLEAR, 8'h03);
    `CHK(irq_o, 1'b0)
    chk_rd(OFS_INT_STATUS, 8'h00);
    chk_rd(OFS_RX_DATA, 8'ha5);
    tx.send(8'h5a, 1'b1, 1'b0, 1'b0);
    chk_rd(OFS_LINE_STATUS, 8'h09);
    // holding register still occupied when this one completes
    tx.send(8'h3c, 1'b1, 1'b0, 1'b1);
    chk_rd(OFS_LINE_STATUS, 8'h03);
    chk_rd(OFS_RX_DATA, 8'h5a);
    chk_rd(OFS_LINE_STATUS, 8'h00);
    $display("test errors done");
  endtask

  task automatic t_fifo();
    wr(OFS_CONFIG, 8'h1f);
    tx.send(8'h11, 1'b1, 1'b0, 1'b1);
    tx.send(8'h22, 1'b1, 1'b1, 1'b1);
    tx.send(8'h44, 1'b1, 1'b0, 1'b0);
    chk_rd(OFS_LINE_STATUS, 8'h81);
    chk_rd(OFS_LINE_STATUS, 8'h01);
    chk_rd(OFS_RX_DATA, 8'h11);
    chk_rd(OFS_LINE_STATUS, 8'h05);
    chk_rd(OFS_RX_DATA, 8'h22);
    chk_rd(OFS_LINE_STATUS, 8'h09);
    chk_rd(OFS_RX_DATA, 8'h44);
    chk_rd(OFS_LINE_STATUS, 8'h00);
    $display("test fifo done");
  endtask

  task automatic t_full();
    for (int i = 0; i < 17; i++) begin
      tx.send(i[7:0], 1'b1, ^i[7:0], 1'b1);
    end
    chk_rd(OFS_LINE_STATUS, 8'h03);
    for (int i = 0; i < 16; i++) begin
      chk_rd(OFS_RX_DATA, i[7:0]);
    end
    // the seventeenth character must not have entered
    chk_rd(OFS_LINE_STATUS, 8'h00);
    $display("test full done");
  endtask

  task automatic t_break();
    tx.hold_low(480);
    chk_rd(OFS_LINE_STATUS, 8'h91);
    chk_rd(OFS_LINE_STATUS, 8'h01);
    chk_rd(OFS_RX_DATA, 8'h00);
    chk_rd(OFS_LINE_STATUS, 8'h00);
    $display("test break done");
  endtask

  // =======================================
  // verdict
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    t_idle();
    t_plain();
    t_errors();
    t_fifo();
    t_full();
    t_break();
    close_out();
  end

  // hang guard well above the expected run length
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    $display("ERROR %0t: run limit reached", $time);
    close_out();
  end
endmodule
